//--- pfp_regs.svh
`ifndef PFP_REGS_SVH
`define PFP_REGS_SVH

`define PFP_ADDR_PROT 4'h0
`define PFP_ADDR_STAT 4'h1
`define PFP_ADDR_MASK 4'h2
`define PFP_ADDR_CMD 4'h3
`define PFP_ADDR_CADDR 4'h4
`define PFP_CFG_BYTE_ADDR 18'h3FF0C
`define PFP_TOP_ADDR 18'h3FFFF
`define PFP_BASE_ADDR 18'h38000
`define PFP_HIGH_MIN_BYTES 18'h00800
`define PFP_LOW_MIN_BYTES 18'h00400
`define PFP_BIT_OPEN 7
`define PFP_BIT_RNV 6
`define PFP_BIT_HDIS 5
`define PFP_BIT_LDIS 2
`define PFP_FAULT_VALUE 8'h7F
`define PFP_ST_VIOL 0
`define PFP_ST_DONE 1
`define PFP_ST_LOADED 2
`define PFP_CMD_PROG 2'h1
`define PFP_CMD_SECT_ERASE 2'h2
`define PFP_CMD_BLOCK_ERASE 2'h3
`define PFP_SECTOR_BYTES 18'h00200
`endif

//--- pfp_pkg.sv
package pfp_pkg;
   typedef enum logic [1:0] {
      PFP_LOAD_REQ = 2'b00,
      PFP_LOAD_WAIT = 2'b01,
      PFP_RUN = 2'b10
   } pfp_state_e;
   typedef struct packed {
      pfp_state_e state;
      logic [7:0] prot;
      logic [2:0] stat;
      logic [2:0] mask;
      logic [1:0] cmd;
      logic [17:0] caddr;
      logic [7:0] rdata;
      logic cfg_rd;
      logic cmd_go;
      logic [1:0] cmd_kind;
      logic [17:0] cmd_addr;
   } pfp_top_s;
endpackage : pfp_pkg

//--- pfp_check_if.sv
`timescale 1ns/10ps
interface pfp_check_if;
   logic [7:0] prot;
   logic [17:0] addr;
   logic block;
   logic hit;
   modport ctl (output prot, output addr, output block, input hit);
   modport chk (input prot, input addr, input block, output hit);
endinterface : pfp_check_if

//--- pfp_range_check.sv
`timescale 1ns/10ps
`include "pfp_regs.svh"
module pfp_range_check
   import pfp_pkg::*;
(
   pfp_check_if.chk chk
);
   function automatic logic in_high(input logic [1:0] sz, input logic [17:0] a);
      logic [17:0] len;
      len = 18'(`PFP_HIGH_MIN_BYTES << sz);
      in_high = a > 18'(`PFP_TOP_ADDR - len);
   endfunction : in_high
   function automatic logic in_low(input logic [1:0] sz, input logic [17:0] a);
      logic [17:0] len;
      len = 18'(`PFP_LOW_MIN_BYTES << sz);
      in_low = (a >= `PFP_BASE_ADDR) && (a < 18'(`PFP_BASE_ADDR + len));
   endfunction : in_low
   logic hr;
   logic lr;
   logic open_b;
   logic he;
   logic le;
   logic anyp;
   always_comb begin
      open_b = chk.prot[`PFP_BIT_OPEN];
      he = ~chk.prot[`PFP_BIT_HDIS];
      le = ~chk.prot[`PFP_BIT_LDIS];
      hr = he && in_high(chk.prot[4:3], chk.addr);
      lr = le && in_low(chk.prot[1:0], chk.addr);
      // Any part of the array protected (block erase)
      if (open_b) begin
         anyp = he || le;
      end else begin
         anyp = 1'b1;
      end
      if (chk.block) begin
         chk.hit = anyp;
      end else if (open_b) begin
         chk.hit = hr || lr;
      end else begin
         chk.hit = ~(hr || lr) || (chk.prot[`PFP_BIT_HDIS] && chk.prot[`PFP_BIT_LDIS]);
      end
   end
endmodule : pfp_range_check

//--- pfp_protect.sv
// Strobed register access and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
`include "pfp_regs.svh"
module pfp_protect
   import pfp_pkg::*;
(
   input wire logic core_clk_in, // System clock
   input wire logic reset_n_in, // Async reset, active low
   input wire logic clk_en_in, // Freezes state when low
   input wire logic [3:0] reg_addr_in, // Register address
   input wire logic [7:0] reg_wdata_in, // Write data
   input wire logic reg_wr_in, // Write strobe
   input wire logic reg_rd_in, // Read strobe
   output logic [7:0] reg_rdata_out, // Read data, cycle after strobe
   output logic [17:0] cfg_addr_out, // Config byte address
   output logic cfg_rd_out, // Config read request
   input wire logic cfg_valid_in, // Config byte valid
   input wire logic [7:0] cfg_data_in, // Config byte
   input wire logic cfg_dbl_fault_in, // Double-bit fault on config read
   output logic cmd_go_out, // Command launched to array
   output logic [1:0] cmd_kind_out, // Launched command kind
   output logic [17:0] cmd_addr_out, // Launched command address
   output logic ready_out, // Protection loaded
   output logic irq_out // Interrupt, level
);
   pfp_top_s r;
   pfp_top_s nxt;
   pfp_check_if cur_if ();
   logic [7:0] cand;
   logic allowed;
   logic new_covers;
   logic [17:0] probe;

   pfp_range_check u_chk_cur (.chk(cur_if.chk));

   // Size fields stay locked while their range is enabled
   function automatic logic [7:0] merge_prot(input logic [7:0] old, input logic [7:0] w);
      logic [7:0] m;
      m = w;
      m[`PFP_BIT_RNV] = old[`PFP_BIT_RNV];
      if (!old[`PFP_BIT_HDIS]) begin
         m[4:3] = old[4:3];
      end
      if (!old[`PFP_BIT_LDIS]) begin
         m[1:0] = old[1:0];
      end
      merge_prot = m;
   endfunction : merge_prot

   // Coverage compare done by an exhaustive 1 kB granule probe over the whole array
   function automatic logic prot_at(input logic [7:0] p, input logic [17:0] a);
      logic [17:0] hl;
      logic [17:0] ll;
      logic h;
      logic l;
      hl = 18'(`PFP_HIGH_MIN_BYTES << p[4:3]);
      ll = 18'(`PFP_LOW_MIN_BYTES << p[1:0]);
      h = !p[`PFP_BIT_HDIS] && (a > 18'(`PFP_TOP_ADDR - hl));
      l = !p[`PFP_BIT_LDIS] && (a >= `PFP_BASE_ADDR) && (a < 18'(`PFP_BASE_ADDR + ll));
      if (p[`PFP_BIT_OPEN]) begin
         prot_at = h || l;
      end else if (p[`PFP_BIT_HDIS] && p[`PFP_BIT_LDIS]) begin
         prot_at = 1'b1;
      end else begin
         prot_at = !(h || l);
      end
   endfunction : prot_at

   always_comb begin
      cand = merge_prot(r.prot, reg_wdata_in);
      new_covers = 1'b1;
      // 1 kB granules cover every range boundary
      for (int i = 0; i < 32; i++) begin
         probe = 18'(`PFP_BASE_ADDR + 18'(i) * 18'h00400);
         if (prot_at(r.prot, probe) && !prot_at(cand, probe)) begin
            new_covers = 1'b0;
         end
      end
      allowed = new_covers;
   end

   assign cur_if.prot = r.prot;
   assign cur_if.addr = r.caddr;
   assign cur_if.block = (r.cmd == `PFP_CMD_BLOCK_ERASE);
   always_comb begin
      nxt = r;
      nxt.cfg_rd = 1'b0;
      nxt.cmd_go = 1'b0;
      nxt.rdata = 8'h00;
      case (r.state)
         PFP_LOAD_REQ: begin
            nxt.cfg_rd = 1'b1;
            nxt.state = PFP_LOAD_WAIT;
         end
         PFP_LOAD_WAIT: begin
            if (cfg_valid_in) begin
               if (cfg_dbl_fault_in) begin
                  nxt.prot = `PFP_FAULT_VALUE;
               end else begin
                  nxt.prot = cfg_data_in;
               end
               nxt.stat[`PFP_ST_LOADED] = 1'b1;
               nxt.state = PFP_RUN;
            end
         end
         PFP_RUN: begin
            if (reg_wr_in) begin
               case (reg_addr_in)
                  `PFP_ADDR_PROT: begin
                     if (allowed) begin
                        nxt.prot = cand;
                     end
                  end
                  `PFP_ADDR_STAT: begin
                     nxt.stat = r.stat & ~reg_wdata_in[2:0];
                  end
                  `PFP_ADDR_MASK: begin
                     nxt.mask = reg_wdata_in[2:0];
                  end
                  `PFP_ADDR_CMD: begin
                     nxt.cmd = reg_wdata_in[1:0];
                  end
                  `PFP_ADDR_CADDR: begin
                     nxt.caddr = {r.caddr[9:0], reg_wdata_in};
                  end
                  default: begin
                  end
               endcase
            end
            // Command launch is checked against the register in force
            if (r.cmd != 2'h0 && !(reg_wr_in && reg_addr_in == `PFP_ADDR_CMD)) begin
               nxt.cmd = 2'h0;
               if (!r.stat[`PFP_ST_VIOL]) begin
                  if (cur_if.hit) begin
                     nxt.stat[`PFP_ST_VIOL] = 1'b1;
                  end else begin
                     nxt.cmd_go = 1'b1;
                     nxt.cmd_kind = r.cmd;
                     nxt.cmd_addr = r.caddr;
                     nxt.stat[`PFP_ST_DONE] = 1'b1;
                  end
               end
            end
         end
         default: begin
            nxt.state = PFP_LOAD_REQ;
         end
      endcase
      if (reg_rd_in) begin
         case (reg_addr_in)
            `PFP_ADDR_PROT: nxt.rdata = r.prot;
            `PFP_ADDR_STAT: nxt.rdata = {5'h00, r.stat};
            `PFP_ADDR_MASK: nxt.rdata = {5'h00, r.mask};
            `PFP_ADDR_CMD: nxt.rdata = {6'h00, r.cmd};
            `PFP_ADDR_CADDR: nxt.rdata = r.caddr[7:0];
            default: nxt.rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         r <= '{state: PFP_LOAD_REQ, prot: `PFP_FAULT_VALUE, stat: 3'h0, mask: 3'h0,
                cmd: 2'h0, caddr: 18'h00000, rdata: 8'h00, cfg_rd: 1'b0, cmd_go: 1'b0,
                cmd_kind: 2'h0, cmd_addr: 18'h00000};
      end else if (clk_en_in) begin
         r <= nxt;
      end
   end

   assign reg_rdata_out = r.rdata;
   assign cfg_addr_out = `PFP_CFG_BYTE_ADDR;
   assign cfg_rd_out = r.cfg_rd;
   assign cmd_go_out = r.cmd_go;
   assign cmd_kind_out = r.cmd_kind;
   assign cmd_addr_out = r.cmd_addr;
   assign ready_out = (r.state == PFP_RUN);
   assign irq_out = |(r.stat & r.mask);
endmodule : pfp_protect

//--- pfp_protect_props.sv
`timescale 1ns/10ps
module pfp_protect_props (
   input wire logic core_clk_in, // Clock
   input wire logic reset_n_in, // Reset
   input wire logic clk_en_in, // Run enable
   input wire logic [3:0] reg_addr_in, // Address
   input wire logic [7:0] reg_wdata_in, // Write data
   input wire logic reg_wr_in, // Write strobe
   input wire logic reg_rd_in, // Read strobe
   input wire logic [7:0] reg_rdata_out, // Read data
   input wire logic [17:0] cfg_addr_out, // Config address
   input wire logic cfg_valid_in, // Config valid
   input wire logic cmd_go_out, // Launch
   input wire logic [1:0] cmd_kind_out, // Launch kind
   input wire logic [17:0] cmd_addr_out, // Launch address
   input wire logic ready_out // Loaded
);
   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (!reset_n_in);
   a_rdata_idle: assert property (
      $past(clk_en_in) && !$past(reg_rd_in) |-> reg_rdata_out == 8'h00)
      else $error("read data outside read slot");
   a_cfg_addr_fixed: assert property (cfg_addr_out == 18'h3FF0C)
      else $error("config address wrong");
   a_load_ready: assert property (clk_en_in && cfg_valid_in && !ready_out |=> ready_out)
      else $error("load not completed");
   a_ready_kept: assert property (ready_out |=> ready_out)
      else $error("ready dropped");
   a_go_unloaded: assert property (!ready_out |-> !cmd_go_out)
      else $error("launch before load");
   a_go_cause: assert property (
      cmd_go_out |-> $past(reg_wr_in && reg_addr_in == 4'h3, 2))
      else $error("launch without command write");
   a_go_kind: assert property (cmd_go_out |-> cmd_kind_out == $past(reg_wdata_in[1:0], 2))
      else $error("launch kind wrong");
   a_go_valid_kind: assert property (cmd_go_out |-> cmd_kind_out != 2'h0)
      else $error("launch of empty command");
   a_addr_held: assert property (!cmd_go_out |-> $stable(cmd_addr_out))
      else $error("launch address moved");
endmodule : pfp_protect_props
bind pfp_protect pfp_protect_props pfp_protect_props_inst (.core_clk_in(core_clk_in),
   .reset_n_in(reset_n_in), .clk_en_in(clk_en_in), .reg_addr_in(reg_addr_in),
   .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
   .reg_rdata_out(reg_rdata_out), .cfg_addr_out(cfg_addr_out), .cfg_valid_in(cfg_valid_in),
   .cmd_go_out(cmd_go_out), .cmd_kind_out(cmd_kind_out), .cmd_addr_out(cmd_addr_out),
   .ready_out(ready_out));

//--- pfp_protect_test.sv
`timescale 1ns/10ps
module pfp_protect_test;
   import pfp_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [3:0] a = 4'h0;
   logic [7:0] wd = 8'h00;
   logic [7:0] cd = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic cv = 1'b0;
   logic cf = 1'b0;
   logic ce = 1'b1;
   logic [7:0] rdat;
   logic [17:0] cfa;
   logic cfr, go, rdy, irq;
   logic [1:0] kind;
   logic [17:0] gaddr;
   int error_cnt = 0;
   int n_compared = 0;
   always #5 clk = ~clk;
   pfp_protect pfp_protect_inst (.core_clk_in(clk), .reset_n_in(rst_n), .clk_en_in(ce),
      .reg_addr_in(a), .reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdat),
      .cfg_addr_out(cfa), .cfg_rd_out(cfr), .cfg_valid_in(cv), .cfg_data_in(cd),
      .cfg_dbl_fault_in(cf), .cmd_go_out(go), .cmd_kind_out(kind), .cmd_addr_out(gaddr),
      .ready_out(rdy), .irq_out(irq));
   task final_report;
      $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : final_report
   task chk(input logic [17:0] got, input logic [17:0] exp);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task chk_irq(input logic exp);
      repeat (2) @(posedge clk);
      #1 chk({17'h0, irq}, {17'h0, exp});
   endtask : chk_irq
   task wrr(input logic [3:0] ad, input logic [7:0] d);
      @(posedge clk);
      a <= ad;
      wd <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wrr
   task rchk(input logic [3:0] ad, input logic [7:0] m, input logic [7:0] exp);
      @(posedge clk);
      a <= ad;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk({10'h0, rdat & m}, {10'h0, exp});
   endtask : rchk
   task boot(input logic [7:0] d, input logic f);
      rst_n <= 1'b0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 10 && cfr !== 1'b1; i++) begin
         @(posedge clk);
         #1;
      end
      chk({17'h0, cfr}, 18'h1);
      @(posedge clk);
      cv <= 1'b1;
      cd <= d;
      cf <= f;
      @(posedge clk);
      cv <= 1'b0;
      repeat (2) @(posedge clk);
      #1 chk({17'h0, rdy}, 18'h1);
   endtask : boot
   task do_cmd(input logic [1:0] k, input logic [17:0] ad, input logic exp, input logic clr);
      logic seen;
      if (clr)
         wrr(4'h1, 8'h01);
      wrr(4'h4, {6'h0, ad[17:16]});
      wrr(4'h4, ad[15:8]);
      wrr(4'h4, ad[7:0]);
      wrr(4'h3, {6'h0, k});
      seen = 1'b0;
      repeat (4) begin
         @(posedge clk);
         #1 seen = seen | (go === 1'b1);
      end
      chk({17'h0, seen}, {17'h0, exp});
      if (exp)
         chk(gaddr, ad);
      if (exp)
         chk({16'h0, kind}, {16'h0, k});
      rchk(4'h1, 8'h01, {7'h0, ~exp});
   endtask : do_cmd
   initial begin
      #100000;
      error_cnt++;
      final_report;
   end
   initial begin
      boot(8'hFF, 1'b0);
      rchk(4'h0, 8'hFF, 8'hFF);
      rchk(4'h1, 8'hFF, 8'h04);
      rchk(4'hF, 8'hFF, 8'h00);
      chk(cfa, 18'h3FF0C);
      do_cmd(2'h3, 18'h38000, 1'b1, 1'b1);
      rchk(4'h1, 8'hFF, 8'h06);
      $display("test load done");
      wrr(4'h0, 8'hF8);
      rchk(4'h0, 8'hFF, 8'hF8);
      do_cmd(2'h1, 18'h383FF, 1'b0, 1'b1);
      rchk(4'h4, 8'hFF, 8'hFF);
      rchk(4'h3, 8'hFF, 8'h00);
      do_cmd(2'h1, 18'h38400, 1'b1, 1'b1);
      do_cmd(2'h3, 18'h3F000, 1'b0, 1'b1);
      do_cmd(2'h2, 18'h3FE00, 1'b1, 1'b1);
      wrr(4'h0, 8'hFF);
      wrr(4'h0, 8'hF9);
      rchk(4'h0, 8'hFF, 8'hF8);
      wrr(4'h0, 8'hD8);
      rchk(4'h0, 8'hFF, 8'hD8);
      do_cmd(2'h1, 18'h3BFFF, 1'b1, 1'b1);
      do_cmd(2'h1, 18'h3C000, 1'b0, 1'b1);
      wrr(4'h0, 8'h58);
      rchk(4'h0, 8'hFF, 8'hD8);
      wrr(4'h0, 8'h7F);
      rchk(4'h0, 8'hFF, 8'h7C);
      do_cmd(2'h1, 18'h38400, 1'b0, 1'b1);
      $display("test upgrade done");
      boot(8'h40, 1'b0);
      do_cmd(2'h1, 18'h3F800, 1'b1, 1'b1);
      do_cmd(2'h1, 18'h383FF, 1'b1, 1'b1);
      do_cmd(2'h3, 18'h38000, 1'b0, 1'b1);
      wrr(4'h2, 8'h01);
      rchk(4'h2, 8'hFF, 8'h01);
      chk_irq(1'b1);
      wrr(4'h1, 8'h00);
      chk_irq(1'b1);
      do_cmd(2'h1, 18'h3F800, 1'b0, 1'b0);
      wrr(4'h1, 8'h01);
      chk_irq(1'b0);
      do_cmd(2'h1, 18'h3F7FF, 1'b0, 1'b1);
      @(posedge clk);
      ce <= 1'b0;
      wrr(4'h0, 8'h7F);
      ce <= 1'b1;
      rchk(4'h0, 8'hFF, 8'h40);
      do_cmd(2'h1, 18'h3FF0C, 1'b1, 1'b1);
      $display("test open polarity done");
      boot(8'hFF, 1'b1);
      rchk(4'h0, 8'hFF, 8'h7F);
      do_cmd(2'h1, 18'h3C000, 1'b0, 1'b1);
      $display("test fault load done");
      final_report;
   end
endmodule : pfp_protect_test
